/* File: hdl/scgb_pkg.sv */
// Package: register map, field layout and types of the sleep clock gate bank
package scgb_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [11:0] SCGB_OFF_RUN_GATE   = 12'h104;
    localparam logic [11:0] SCGB_OFF_SLEEP_GATE = 12'h114;
    localparam logic [11:0] SCGB_OFF_DEEP_GATE  = 12'h124;
    localparam logic [11:0] SCGB_OFF_RUN_CFG    = 12'h060;
    localparam logic [11:0] SCGB_OFF_MODE       = 12'h200;
    localparam logic [11:0] SCGB_OFF_IRQ_STAT   = 12'h204;
    localparam logic [11:0] SCGB_OFF_IRQ_EN     = 12'h208;
    localparam logic [11:0] SCGB_OFF_IRQ_CLR    = 12'h20C;
    localparam logic [11:0] SCGB_OFF_FAULT_ADDR = 12'h210;

    // ************************************************************
    // Field layout and reset values
    // ************************************************************
    localparam logic [31:0] SCGB_GATE_WMASK  = 32'h0707_1133;
    localparam logic [31:0] SCGB_GATE_RESET  = 32'h0000_0000;
    localparam int          SCGB_AUTO_GATE_BIT = 27;
    localparam logic [31:0] SCGB_RUN_CFG_RESET = 32'h0000_0000;
    localparam int          SCGB_NUM_UNITS   = 11;
    localparam int          SCGB_IRQ_FAULT   = 0;
    localparam int          SCGB_IRQ_UNMAPPED = 1;
    localparam int          SCGB_IRQ_W       = 2;

    // Gate bit of each unit, in unit index order
    localparam int SCGB_UNIT_BIT [SCGB_NUM_UNITS] =
        '{0, 1, 4, 5, 8, 12, 16, 17, 18, 24, 25};
    localparam int SCGB_UNIT_BIT_LAST = 26;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0]
    {
        SCGB_MODE_RUN   = 3'b001,
        SCGB_MODE_SLEEP = 3'b010,
        SCGB_MODE_DEEP  = 3'b100
    } scgb_mode_e;

    typedef struct packed
    {
        logic        valid;
        logic        write;
        logic [3:0]  unit;
    } scgb_unit_req_s;

endpackage : scgb_pkg

/* File: hdl/scgb_top.sv */
// Sleep-mode clock gate bank with APB register slave and unit access check
module scgb_top
    import scgb_pkg::*;
(
    // Clock and reset
    input  wire logic                  core_clk,
    input  wire logic                  rst_n,
    // APB slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [11:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    // Unit access check from the system bus
    input  scgb_pkg::scgb_unit_req_s   unit_req,
    output logic                       unit_fault,
    // Unit clock enables, in unit index order
    output logic [10:0]                unit_clk_en,
    // Interrupt
    output logic                       irq
);
    import scgb_pkg::*;

    // ************************************************************
    // Reset release
    // ************************************************************
    logic rst_s1_q;
    logic rst_s2_q;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    wire logic rstn_i = rst_s2_q;

    // ************************************************************
    // APB decode
    // ************************************************************
    logic        acc;
    logic        wr;
    logic        mapped;
    logic [31:0] rd_d;
    assign acc = psel && penable && pready;
    assign wr  = acc && pwrite;

    logic [31:0] run_gate_q;
    logic [31:0] sleep_gate_q;
    logic [31:0] deep_gate_q;
    logic [31:0] run_cfg_q;
    scgb_mode_e  mode_q;
    logic [SCGB_IRQ_W-1:0] irq_stat_q;
    logic [SCGB_IRQ_W-1:0] irq_en_q;
    logic [31:0] fault_addr_q;

    always_comb
    begin
        mapped = 1'b1;
        rd_d   = 32'h0000_0000;
        case (paddr)
            SCGB_OFF_RUN_GATE:   rd_d = run_gate_q;
            SCGB_OFF_SLEEP_GATE: rd_d = sleep_gate_q;
            SCGB_OFF_DEEP_GATE:  rd_d = deep_gate_q;
            SCGB_OFF_RUN_CFG:    rd_d = run_cfg_q;
            SCGB_OFF_MODE:       rd_d = {29'h0, mode_q};
            SCGB_OFF_IRQ_STAT:   rd_d = {30'h0, irq_stat_q};
            SCGB_OFF_IRQ_EN:     rd_d = {30'h0, irq_en_q};
            SCGB_OFF_IRQ_CLR:    rd_d = 32'h0000_0000;
            SCGB_OFF_FAULT_ADDR: rd_d = fault_addr_q;
            default:             mapped = 1'b0;
        endcase
    end

    // One wait state: ready rises in the access phase, answer then
    always_ff @(posedge core_clk or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready  <= psel && penable && !pready;
            prdata  <= (psel && penable && !pready && !pwrite) ? rd_d : 32'h0000_0000;
            pslverr <= psel && penable && !pready && !mapped;
        end
    end

    // ************************************************************
    // Gate registers
    // ************************************************************
    // Reserved bits are masked away on write so they always read zero
    always_ff @(posedge core_clk or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            run_gate_q   <= SCGB_GATE_RESET;
            sleep_gate_q <= SCGB_GATE_RESET;
            deep_gate_q  <= SCGB_GATE_RESET;
        end
        else if (wr && !pslverr)
        begin
            if (paddr == SCGB_OFF_RUN_GATE)
                run_gate_q <= pwdata & SCGB_GATE_WMASK;
            if (paddr == SCGB_OFF_SLEEP_GATE)
                sleep_gate_q <= pwdata & SCGB_GATE_WMASK;
            if (paddr == SCGB_OFF_DEEP_GATE)
                deep_gate_q <= pwdata & SCGB_GATE_WMASK;
        end
    end

    always_ff @(posedge core_clk or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            run_cfg_q <= SCGB_RUN_CFG_RESET;
            mode_q    <= SCGB_MODE_RUN;
        end
        else if (wr)
        begin
            if (paddr == SCGB_OFF_RUN_CFG)
                run_cfg_q <= pwdata;
            if (paddr == SCGB_OFF_MODE)
            begin
                case (pwdata[2:0])
                    SCGB_MODE_SLEEP: mode_q <= SCGB_MODE_SLEEP;
                    SCGB_MODE_DEEP:  mode_q <= SCGB_MODE_DEEP;
                    default:         mode_q <= SCGB_MODE_RUN;
                endcase
            end
        end
    end

    // ************************************************************
    // Active gate selection
    // ************************************************************
    logic        auto_gating_select;
    logic [31:0] act_gate;
    assign auto_gating_select = run_cfg_q[SCGB_AUTO_GATE_BIT];

    always_comb
    begin
        act_gate = run_gate_q;
        if (auto_gating_select)
        begin
            case (mode_q)
                SCGB_MODE_SLEEP: act_gate = sleep_gate_q;
                SCGB_MODE_DEEP:  act_gate = deep_gate_q;
                default:         act_gate = run_gate_q;
            endcase
        end
    end

    // Unit order: async 0,1; sync 0,1; encoder; two-wire; counters 0..2; comparators 0,1
    logic [10:0] en_d;
    always_comb
    begin
        en_d[0]  = act_gate[0];
        en_d[1]  = act_gate[1];
        en_d[2]  = act_gate[4];
        en_d[3]  = act_gate[5];
        en_d[4]  = act_gate[8];
        en_d[5]  = act_gate[12];
        en_d[6]  = act_gate[16];
        en_d[7]  = act_gate[17];
        en_d[8]  = act_gate[18];
        en_d[9]  = act_gate[24];
        en_d[10] = act_gate[25];
    end

    // Comparator 2 sits on bit 26; its enable only feeds the fault check, not unit_clk_en
    logic cmp2_en;
    assign cmp2_en = act_gate[SCGB_UNIT_BIT_LAST];

    always_ff @(posedge core_clk or negedge rstn_i)
    begin
        if (!rstn_i)
            unit_clk_en <= 11'h000;
        else
            unit_clk_en <= en_d;
    end

    // ************************************************************
    // Unit access fault
    // ************************************************************
    // Unit index 11 addresses comparator 2; above that nothing is gated
    logic req_off;
    always_comb
    begin
        if (unit_req.unit == 4'hB)
            req_off = !cmp2_en;
        else if (unit_req.unit > 4'hA)
            req_off = 1'b0;
        else
            req_off = !en_d[unit_req.unit];
    end

    always_ff @(posedge core_clk or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            unit_fault   <= 1'b0;
            fault_addr_q <= 32'h0000_0000;
        end
        else
        begin
            unit_fault <= unit_req.valid && req_off;
            if (unit_req.valid && req_off)
                fault_addr_q <= {26'h0, unit_req.write, 1'b0, unit_req.unit};
        end
    end

    // ************************************************************
    // Interrupts
    // ************************************************************
    logic [SCGB_IRQ_W-1:0] ev;
    assign ev = {pslverr && pready, unit_fault};

    // Set wins over a clear in the same cycle
    always_ff @(posedge core_clk or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            irq_stat_q <= '0;
            irq_en_q   <= '0;
            irq        <= 1'b0;
        end
        else
        begin
            if (wr && paddr == SCGB_OFF_IRQ_CLR)
                irq_stat_q <= (irq_stat_q & ~pwdata[SCGB_IRQ_W-1:0]) | ev;
            else
                irq_stat_q <= irq_stat_q | ev;
            if (wr && paddr == SCGB_OFF_IRQ_EN)
                irq_en_q <= pwdata[SCGB_IRQ_W-1:0];
            irq <= |(irq_stat_q & irq_en_q);
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    AST_RESET_ZERO: assert property (@(posedge core_clk) !rstn_i |=> unit_clk_en == 11'h000)
        else $error("Enables not zero after reset");
    AST_FAULT_OFF: assert property (@(posedge core_clk) disable iff (!rstn_i)
        unit_req.valid && unit_req.unit < 4'hB && !en_d[unit_req.unit] |=> unit_fault)
        else $error("Access to gated unit did not fault");
    AST_NO_FAULT_ON: assert property (@(posedge core_clk) disable iff (!rstn_i)
        unit_req.valid && unit_req.unit < 4'hB && en_d[unit_req.unit] |=> !unit_fault)
        else $error("Fault on clocked unit");
    AST_RSVD_ZERO: assert property (@(posedge core_clk) disable iff (!rstn_i)
        (sleep_gate_q & ~SCGB_GATE_WMASK) == 32'h0)
        else $error("Reserved bit set");
    AST_SLEEP_USED: assert property (@(posedge core_clk) disable iff (!rstn_i)
        auto_gating_select && mode_q == SCGB_MODE_SLEEP |=> unit_clk_en[6] == $past(sleep_gate_q[16]))
        else $error("Sleep gate not applied");
    AST_RUN_USED: assert property (@(posedge core_clk) disable iff (!rstn_i)
        !auto_gating_select |=> unit_clk_en[5] == $past(run_gate_q[12]))
        else $error("Run gate not governing");
    AST_SLEEP_WRITE: assert property (@(posedge core_clk) disable iff (!rstn_i)
        wr && paddr == SCGB_OFF_SLEEP_GATE |=> sleep_gate_q[8] == $past(pwdata[8]))
        else $error("Sleep gate write lost");
    AST_IRQ_LEVEL: assert property (@(posedge core_clk) disable iff (!rstn_i)
        |(irq_stat_q & irq_en_q) |=> irq)
        else $error("Interrupt not raised");
    AST_IRQ_DROP: assert property (@(posedge core_clk) disable iff (!rstn_i)
        !(|(irq_stat_q & irq_en_q)) |=> !irq)
        else $error("Interrupt high with nothing pending");
    AST_PREADY_PULSE: assert property (@(posedge core_clk) disable iff (!rstn_i)
        pready |=> !pready)
        else $error("Ready held longer than one cycle");
    AST_UNMAPPED_ERR: assert property (@(posedge core_clk) disable iff (!rstn_i)
        psel && penable && !pready && !mapped |=> pready && pslverr)
        else $error("Unmapped access without error");
    AST_RUN_RSVD: assert property (@(posedge core_clk) disable iff (!rstn_i)
        (run_gate_q & ~SCGB_GATE_WMASK) == 32'h0)
        else $error("Reserved run gate bit set");
    AST_DEEP_RSVD: assert property (@(posedge core_clk) disable iff (!rstn_i)
        (deep_gate_q & ~SCGB_GATE_WMASK) == 32'h0)
        else $error("Reserved deep gate bit set");
    AST_DEEP_USED: assert property (@(posedge core_clk) disable iff (!rstn_i)
        auto_gating_select && mode_q == SCGB_MODE_DEEP |=> unit_clk_en[4] == $past(deep_gate_q[8]))
        else $error("Deep gate not applied");
    AST_COUNTER_MAP: assert property (@(posedge core_clk) disable iff (!rstn_i)
        1'b1 |=> unit_clk_en[8:6] == $past(act_gate[18:16]))
        else $error("Counter enables misrouted");
    AST_TWO_WIRE_MAP: assert property (@(posedge core_clk) disable iff (!rstn_i)
        1'b1 |=> unit_clk_en[5] == $past(act_gate[12]))
        else $error("Two-wire enable misrouted");
    AST_ENCODER_MAP: assert property (@(posedge core_clk) disable iff (!rstn_i)
        1'b1 |=> unit_clk_en[4] == $past(act_gate[8]))
        else $error("Encoder enable misrouted");
    AST_SYNC_MAP: assert property (@(posedge core_clk) disable iff (!rstn_i)
        1'b1 |=> unit_clk_en[3:2] == $past(act_gate[5:4]))
        else $error("Sync serial enables misrouted");
    AST_ASYNC_MAP: assert property (@(posedge core_clk) disable iff (!rstn_i)
        1'b1 |=> unit_clk_en[1:0] == $past(act_gate[1:0]))
        else $error("Async port enables misrouted");
    AST_CMP_MAP: assert property (@(posedge core_clk) disable iff (!rstn_i)
        1'b1 |=> unit_clk_en[10:9] == $past(act_gate[25:24]))
        else $error("Comparator enables misrouted");
    AST_CMP2_FAULT: assert property (@(posedge core_clk) disable iff (!rstn_i)
        unit_req.valid && unit_req.unit == 4'hB && !cmp2_en |=> unit_fault)
        else $error("Gated comparator 2 did not fault");
    AST_CMP2_OK: assert property (@(posedge core_clk) disable iff (!rstn_i)
        unit_req.valid && unit_req.unit == 4'hB && cmp2_en |=> !unit_fault)
        else $error("Fault on clocked comparator 2");
    // Covers for the main scenarios
    COV_DEEP: cover property (@(posedge core_clk) auto_gating_select && mode_q == SCGB_MODE_DEEP);
    COV_BUS_ERR: cover property (@(posedge core_clk) pready && pslverr);
    COV_FAULT: cover property (@(posedge core_clk) unit_fault);
    COV_SLEEP: cover property (@(posedge core_clk) auto_gating_select && mode_q == SCGB_MODE_SLEEP);
    COV_IRQ: cover property (@(posedge core_clk) irq);

endmodule : scgb_top

/* File: test/test_sleep_mode_clock_gate_bank.sv */
// Self-checking bench for the sleep clock gate bank
module test_sleep_mode_clock_gate_bank
    import scgb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [31:0] GATE_MASK = 32'h0707_1133;

    logic           core_clk = 1'b0;
    logic           rst_n;
    logic           psel     = 1'b0;
    logic           penable  = 1'b0;
    logic           pwrite   = 1'b0;
    logic [11:0]    paddr    = 12'h000;
    logic [31:0]    pwdata   = 32'h0;
    logic           pready;
    logic [31:0]    prdata;
    logic           pslverr;
    scgb_unit_req_s unit_req = '0;
    logic           unit_fault;
    logic [10:0]    unit_clk_en;
    logic           irq;
    int             err_count = 0;
    int             n_checks  = 0;
    integer         seed      = 32'hbd1a;
    logic [33:0]    apb_q[$];
    logic           fault_q[$];
    logic [11:0]    out_q[$];
    logic [33:0]    apb_exp;
    logic           req_seen = 1'b0;
    logic [10:0]    en_exp   = 11'h0;

    always #12.5 core_clk = ~core_clk;

    scgb_top dut
    (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .psel        (psel),
        .penable     (penable),
        .pwrite      (pwrite),
        .paddr       (paddr),
        .pwdata      (pwdata),
        .pready      (pready),
        .prdata      (prdata),
        .pslverr     (pslverr),
        .unit_req    (unit_req),
        .unit_fault  (unit_fault),
        .unit_clk_en (unit_clk_en),
        .irq         (irq)
    );

    // ************************************************************
    // Comparison and closing
    // ************************************************************
    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask : check

    task report_and_stop();
        $display("checks %0d, mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : report_and_stop

    // ************************************************************
    // Output monitor: oldest note against each result
    // ************************************************************
    always @(posedge core_clk)
    begin
        if (psel && penable && pready === 1'b1)
        begin
            apb_exp = apb_q.pop_front();
            check("pslverr", {31'h0, apb_exp[32]}, {31'h0, pslverr});
            if (!apb_exp[33] && !apb_exp[32])
                check("prdata", apb_exp[31:0], prdata);
        end
        if (req_seen)
            check("unit_fault", {31'h0, fault_q.pop_front()}, {31'h0, unit_fault});
        req_seen = unit_req.valid;
        if (out_q.size() > 0)
            check("irq_clk_en", {20'h0, out_q.pop_front()}, {20'h0, irq, unit_clk_en});
    end

    // ************************************************************
    // Drivers
    // ************************************************************
    // For reads d carries the expected data; the slave ignores pwdata then
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic err);
        apb_q.push_back({wr, err, d});
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1)
            @(posedge core_clk);
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Back-to-back requests to every unit, comparator 2 last
    task units(input logic [31:0] g);
        for (int u = 0; u < 12; u++)
        begin
            @(posedge core_clk);
            unit_req <= '{valid: 1'b1, write: 1'($random(seed)), unit: 4'(u)};
            fault_q.push_back(!g[u < 11 ? SCGB_UNIT_BIT[u] : SCGB_UNIT_BIT_LAST]);
        end
        @(posedge core_clk);
        unit_req <= '0;
    endtask : units

    // Enables and interrupt are registered, so let them settle
    task probe(input logic ir);
        repeat (3) @(posedge core_clk);
        out_q.push_back({ir, en_exp});
        @(posedge core_clk);
    endtask : probe

    task mode_case(input logic [2:0] m, input logic ag);
        logic [31:0] r;
        logic [31:0] s;
        logic [31:0] dp;
        logic [31:0] g;
        r  = $random(seed);
        s  = $random(seed);
        dp = $random(seed);
        apb(1'b1, SCGB_OFF_RUN_GATE, r, 1'b0);
        apb(1'b1, SCGB_OFF_SLEEP_GATE, s, 1'b0);
        apb(1'b1, SCGB_OFF_DEEP_GATE, dp, 1'b0);
        apb(1'b1, SCGB_OFF_RUN_CFG, 32'(ag) << SCGB_AUTO_GATE_BIT, 1'b0);
        apb(1'b1, SCGB_OFF_MODE, {29'h0, m}, 1'b0);
        apb(1'b0, SCGB_OFF_SLEEP_GATE, s & GATE_MASK, 1'b0);
        g = !ag ? r : (m == 3'h2) ? s : (m == 3'h4) ? dp : r;
        for (int i = 0; i < 11; i++)
            en_exp[i] = g[SCGB_UNIT_BIT[i]];
        probe(1'b0);
        units(g);
    endtask : mode_case

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        rst_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge core_clk);
        apb(1'b0, SCGB_OFF_SLEEP_GATE, 32'h0, 1'b0);
        apb(1'b0, SCGB_OFF_RUN_GATE, 32'h0, 1'b0);
        probe(1'b0);
        units(32'h0);
        apb(1'b1, SCGB_OFF_SLEEP_GATE, 32'hFFFF_FFFF, 1'b0);
        apb(1'b0, SCGB_OFF_SLEEP_GATE, 32'h0707_1133, 1'b0);
        for (int a = 0; a < 2; a++)
            for (int k = 0; k < 3; k++)
                mode_case(3'(1 << k), a[0]);
        // Unmapped accesses raise the bus error event
        apb(1'b1, 12'h300, 32'hFFFF_FFFF, 1'b1);
        apb(1'b0, 12'h300, 32'h0, 1'b1);
        apb(1'b0, SCGB_OFF_IRQ_STAT, 32'h3, 1'b0);
        apb(1'b1, SCGB_OFF_IRQ_EN, 32'h3, 1'b0);
        probe(1'b1);
        apb(1'b1, SCGB_OFF_IRQ_CLR, 32'h1, 1'b0);
        apb(1'b0, SCGB_OFF_IRQ_STAT, 32'h2, 1'b0);
        probe(1'b1);
        apb(1'b1, SCGB_OFF_IRQ_EN, 32'h1, 1'b0);
        probe(1'b0);
        apb(1'b1, SCGB_OFF_IRQ_CLR, 32'h2, 1'b0);
        apb(1'b0, SCGB_OFF_IRQ_STAT, 32'h0, 1'b0);
        report_and_stop();
    end

    // Whole run needs a few hundred cycles
    initial
    begin
        repeat (20000) @(posedge core_clk);
        err_count++;
        report_and_stop();
    end

endmodule : test_sleep_mode_clock_gate_bank
